/* File: hw/cmp_ctrl_pkg.sv */
// Constants and carrier types for the comparator control and output logic.
// Assumes one clock at 100 MHz and an analog core that reports a raw
// comparison bit per comparator, synchronous to that clock.
// Operation
// - Raw result high when plus exceeds minus
// - Enable runs comparator, clear powers down
// - Result readable in control and shared register
// - Pin driven when enabled, output, and on
// - Output enable overrides port latch regardless
// - Internal output latched each instruction cycle
// - Polarity bit inverts comparator output
// - Speed select resets to one, normal
// - Hysteresis bit adds hysteresis per speed
// - Sync re-latches on timer clock fall
// - Output offered as timer gate source
// - Separate rise and fall detectors, enables
// - Enabled edge sets interrupt flag
// - Software clears flag, new edge wins
// - Interrupt needs three enables all set
// - Positive select picks one of four
// - Negative select picks one of four pins
// - Disabled comparator disconnects all inputs
// - Polarity or enable toggle can interrupt
// - Outputs feed PWM auto-shutdown logic
// - Analog pins read zero on port

package cmp_ctrl_pkg;

	// ==========================================================
	// Sizes, reset values and timing.
	localparam int          NUM_CMP           = 2;
	localparam int          INSTR_CLK_PER_CYC = 4;
	localparam int          CLK_PERIOD_NS     = 10;
	localparam int          CYC_CNT_W         = 2;
	localparam logic        SPEED_RESET       = 1'h1;
	localparam logic        OFF_RESET         = 1'h0;

	// ==========================================================
	// Channel select encodings.
	localparam logic [1:0]  PCH_PIN           = 2'h0;
	localparam logic [1:0]  PCH_CONVERTER     = 2'h1;
	localparam logic [1:0]  PCH_FIXED_REF     = 2'h2;
	localparam logic [1:0]  PCH_GROUND        = 2'h3;

	// ==========================================================
	// Per-comparator control bits.
	typedef struct packed {
		logic       cmpEnable;
		logic       pinOutputEnable;
		logic       outputInvert;
		logic       speedPowerSelect;
		logic       hysteresisEnable;
		logic       timerSyncEnable;
		logic       riseEdgeEnable;
		logic       fallEdgeEnable;
		logic       cmpIrqEnable;
		logic [1:0] positiveChannelSelect;
		logic [1:0] negativeChannelSelect;
	} cmp_cfg_t;

	// Analog core controls for one comparator.
	typedef struct packed {
		logic       powerOn;
		logic       fastMode;
		logic       hystOn;
		logic       posConnect;
		logic [1:0] posSel;
		logic       negConnect;
		logic [1:0] negSel;
	} analog_ctl_t;

	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} instr_phase_t;

endpackage

/* File: hw/cmp_channel.sv */
// One comparator channel: polarity, cycle latch, timer sync, edge flag.
// Assumes the instruction strobe and timer clock level are synchronous.
`timescale 1ns/1ps

module cmp_channel
(
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire cmp_ctrl_pkg::cmp_cfg_t cfg,
	input  wire logic                 rawResult,
	input  wire logic                 instrStrobe,
	input  wire logic                 timerClkLevel,
	input  wire logic                 flagClear,
	output logic                      polOut,
	output logic                      cmpResult_q,
	output logic                      syncResult_q,
	output logic                      irqFlag_q
);

	logic timerClk_q;
	logic prevResult_q;
	logic riseHit;
	logic fallHit;
	logic edgeHit;

	// ==========================================================
	// Polarity and disabled output.
	// polarity applied
	assign polOut = (cfg.cmpEnable & rawResult) ^ cfg.outputInvert;

	// ==========================================================
	// Instruction cycle latch.
	// cycle latch
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			cmpResult_q <= 1'h0;
		else if (instrStrobe)
			cmpResult_q <= polOut;
	end

	// ==========================================================
	// Timer clock falling edge re-latch.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			timerClk_q <= 1'h0;
		else
			timerClk_q <= timerClkLevel;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			syncResult_q <= 1'h0;
		else if (!cfg.timerSyncEnable)
			syncResult_q <= cmpResult_q;
		else if (timerClk_q && !timerClkLevel)
			syncResult_q <= cmpResult_q;
	end

	// ==========================================================
	// Edge detectors and flag.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			prevResult_q <= 1'h0;
		else
			prevResult_q <= cmpResult_q;
	end

	assign riseHit = cmpResult_q & ~prevResult_q;
	assign fallHit = ~cmpResult_q & prevResult_q;
	assign edgeHit = (riseHit & cfg.riseEdgeEnable)
		| (fallHit & cfg.fallEdgeEnable);

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			irqFlag_q <= 1'h0;
		else if (edgeHit)
			irqFlag_q <= 1'h1;
		else if (flagClear)
			irqFlag_q <= 1'h0;
	end

	a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!arst_n)
		edgeHit |=> irqFlag_q)
		else $error("Flag not set after enabled edge.");

	a_flag_rise_cause: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		$rose(irqFlag_q) |-> $past(edgeHit))
		else $error("Flag rose without an enabled edge.");

	a_latch_on_strobe: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		!$past(instrStrobe) |-> $stable(cmpResult_q))
		else $error("Latched result moved off the strobe.");

	a_sync_on_fall: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(cfg.timerSyncEnable && !(timerClk_q && !timerClkLevel))
		|=> $stable(syncResult_q))
		else $error("Synced result moved off a timer fall.");

endmodule

/* File: hw/comparator_output_control.sv */
// Top of the comparator control and output logic for NUM_CMP comparators.
// Assumes all inputs synchronous to ref_clk and the analog core outside.
`timescale 1ns/1ps

module comparator_output_control
#(
	parameter int NUM_CMP = cmp_ctrl_pkg::NUM_CMP,
	parameter int NUM_PIN = 8
)
(
	input  wire logic                          ref_clk,
	input  wire logic                          arst_n,
	input  wire cmp_ctrl_pkg::cmp_cfg_t [NUM_CMP-1:0] cmpCfg,
	input  wire logic [NUM_CMP-1:0]            rawResult,
	input  wire logic                          timerClkLevel,
	input  wire logic [NUM_CMP-1:0]            flagClear,
	input  wire logic                          peripheralIrqEnable,
	input  wire logic                          globalIrqEnable,
	input  wire logic [NUM_CMP-1:0]            pinDirection,
	input  wire logic [NUM_CMP-1:0]            portLatch,
	input  wire logic [NUM_PIN-1:0]            portPinIn,
	input  wire logic [NUM_PIN-1:0]            analogPinSelect,
	output cmp_ctrl_pkg::analog_ctl_t [NUM_CMP-1:0] analogCtl_q,
	output logic [NUM_CMP-1:0]                 cmpResult_q,
	output logic [NUM_CMP-1:0]                 sharedResultReg_q,
	output logic [NUM_CMP-1:0]                 irqFlag_q,
	output logic                               cpuIrq_q,
	output logic [NUM_CMP-1:0]                 timerGate_q,
	output logic [NUM_CMP-1:0]                 pwmShutdown_q,
	output logic [NUM_CMP-1:0]                 pinOut_q,
	output logic [NUM_CMP-1:0]                 pinOe_q,
	output logic [NUM_PIN-1:0]                 portRead_q
);

	cmp_ctrl_pkg::instr_phase_t phase_q;
	logic                       instrStrobe;
	logic [NUM_CMP-1:0]         polOut;
	logic [NUM_CMP-1:0]         latched;
	logic [NUM_CMP-1:0]         synced;
	logic [NUM_CMP-1:0]         flags;

	// ==========================================================
	// Instruction cycle phase counter.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			phase_q <= cmp_ctrl_pkg::PH_Q1;
		else
			unique case (phase_q)
				cmp_ctrl_pkg::PH_Q1: phase_q <= cmp_ctrl_pkg::PH_Q2;
				cmp_ctrl_pkg::PH_Q2: phase_q <= cmp_ctrl_pkg::PH_Q3;
				cmp_ctrl_pkg::PH_Q3: phase_q <= cmp_ctrl_pkg::PH_Q4;
				cmp_ctrl_pkg::PH_Q4: phase_q <= cmp_ctrl_pkg::PH_Q1;
			endcase
	end

	assign instrStrobe = (phase_q == cmp_ctrl_pkg::PH_Q4);

	// ==========================================================
	// Comparator channels.
	generate
		for (genvar i = 0; i < NUM_CMP; i++)
		begin : g_cmp
			cmp_channel u_chan (
				.ref_clk       (ref_clk),
				.arst_n        (arst_n),
				.cfg           (cmpCfg[i]),
				.rawResult     (rawResult[i]),
				.instrStrobe   (instrStrobe),
				.timerClkLevel (timerClkLevel),
				.flagClear     (flagClear[i]),
				.polOut        (polOut[i]),
				.cmpResult_q   (latched[i]),
				.syncResult_q  (synced[i]),
				.irqFlag_q     (flags[i])
			);

			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					analogCtl_q[i].powerOn    <= cmp_ctrl_pkg::OFF_RESET;
					analogCtl_q[i].fastMode   <= cmp_ctrl_pkg::SPEED_RESET;
					analogCtl_q[i].hystOn     <= 1'h0;
					analogCtl_q[i].posConnect <= 1'h0;
					analogCtl_q[i].posSel     <= cmp_ctrl_pkg::PCH_PIN;
					analogCtl_q[i].negConnect <= 1'h0;
					analogCtl_q[i].negSel     <= 2'h0;
				end
				else
				begin
					analogCtl_q[i].powerOn    <= cmpCfg[i].cmpEnable;
					analogCtl_q[i].fastMode   <= cmpCfg[i].speedPowerSelect;
					analogCtl_q[i].hystOn     <= cmpCfg[i].hysteresisEnable;
					analogCtl_q[i].posConnect <= cmpCfg[i].cmpEnable;
					analogCtl_q[i].posSel     <=
						cmpCfg[i].positiveChannelSelect;
					analogCtl_q[i].negConnect <= cmpCfg[i].cmpEnable;
					analogCtl_q[i].negSel     <=
						cmpCfg[i].negativeChannelSelect;
				end
			end

			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					pinOut_q[i] <= 1'h0;
					pinOe_q[i]  <= 1'h0;
				end
				else
				begin
					pinOut_q[i] <= cmpCfg[i].pinOutputEnable ? polOut[i]
						: portLatch[i];
					pinOe_q[i]  <= ~pinDirection[i]
						& (~cmpCfg[i].pinOutputEnable | cmpCfg[i].cmpEnable);
				end
			end
		end
	endgenerate

	// ==========================================================
	// Result, gate, shutdown and flag outputs.
	// result fan-out
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cmpResult_q       <= '0;
			sharedResultReg_q <= '0;
			timerGate_q       <= '0;
			pwmShutdown_q     <= '0;
			irqFlag_q         <= '0;
		end
		else
		begin
			cmpResult_q       <= latched;
			sharedResultReg_q <= latched;
			timerGate_q       <= synced;
			pwmShutdown_q     <= polOut;
			irqFlag_q         <= flags;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			cpuIrq_q <= 1'h0;
		else
		begin
			cpuIrq_q <= 1'h0;
			for (int k = 0; k < NUM_CMP; k++)
				if (flags[k] && cmpCfg[k].cmpIrqEnable)
					cpuIrq_q <= peripheralIrqEnable & globalIrqEnable;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			portRead_q <= '0;
		else
			portRead_q <= portPinIn & ~analogPinSelect;
	end

	a_irq_needs_gie: assert property (@(posedge ref_clk) disable iff (!arst_n)
		cpuIrq_q |-> $past(globalIrqEnable && peripheralIrqEnable))
		else $error("Interrupt raised without both enables.");

	a_analog_reads_zero: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		##1 ($past(analogPinSelect) & portRead_q) == '0)
		else $error("Analog pin read as one.");

	a_pin_drive: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(cmpCfg[0].pinOutputEnable && !pinDirection[0]
		 && cmpCfg[0].cmpEnable) |=> pinOe_q[0] && pinOut_q[0] == $past(polOut[0]))
		else $error("Pin not driven by comparator.");

	a_shared_match: assert property (@(posedge ref_clk) disable iff (!arst_n)
		sharedResultReg_q == cmpResult_q)
		else $error("Shared result differs from status bit.");

	a_off_disconnect: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!cmpCfg[0].cmpEnable |=> !analogCtl_q[0].posConnect
		&& !analogCtl_q[0].negConnect && !analogCtl_q[0].powerOn)
		else $error("Inputs connected while disabled.");

endmodule

/* File: verif/far_side_model.sv */
// Far-side model: analog sources, comparator core and gated timer.
// Assumes analog controls from the block and source levels from the bench.
`timescale 1ns/1ps
module far_side_model
#(
	parameter int N = cmp_ctrl_pkg::NUM_CMP
)
(
	input  wire logic                              ref_clk,
	input  wire logic                              arst_n,
	input  wire logic                              timerRun,
	input  wire logic [3:0][7:0]                   plusSrc,
	input  wire logic [3:0][7:0]                   minusSrc,
	input  wire cmp_ctrl_pkg::analog_ctl_t [N-1:0] analogCtl,
	input  wire logic [N-1:0]                      timerGate,
	output logic [N-1:0]                           rawResult,
	output logic                                   timerClkLevel
);
	// ==========================================================
	// Comparator core and a timer clock that stands high when stopped.
	logic [1:0]  divCnt_q;
	logic [15:0] timerCount_q;
	always_comb
	begin
		for (int i = 0; i < N; i++)
			rawResult[i] = analogCtl[i].powerOn
				& (((analogCtl[i].posSel == cmp_ctrl_pkg::PCH_GROUND)
				? 8'h00 : plusSrc[analogCtl[i].posSel])
				> minusSrc[analogCtl[i].negSel]);
	end
	assign timerClkLevel = divCnt_q[1];
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			divCnt_q <= 2'h2;
		else
			divCnt_q <= timerRun ? divCnt_q + 2'h1 : 2'h2;
	end
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			timerCount_q <= 16'h0000;
		else if (divCnt_q == 2'h1 && timerGate[0])
			timerCount_q <= timerCount_q + 16'h0001;
	end
endmodule

/* File: verif/tb_comparator_output_control.sv */
// Self-checking bench for the comparator control and output logic.
// Assumes the far-side model supplies raw results and the timer clock.
`timescale 1ns/1ps
module tb_comparator_output_control;
	// ==========================================================
	// Signals and instances.
	localparam int N = cmp_ctrl_pkg::NUM_CMP;
	logic                              ref_clk, arst_n, timerRun;
	logic                              timerClkLevel, cpuIrq_q;
	logic                              peripheralIrqEnable, globalIrqEnable;
	logic [3:0][7:0]                   plusSrc, minusSrc;
	cmp_ctrl_pkg::cmp_cfg_t [N-1:0]    cmpCfg;
	cmp_ctrl_pkg::analog_ctl_t [N-1:0] analogCtl_q;
	logic [N-1:0]                      rawResult, flagClear, pinDirection;
	logic [N-1:0]                      portLatch, cmpResult_q, irqFlag_q;
	logic [N-1:0]                      sharedResultReg_q, timerGate_q;
	logic [N-1:0]                      pwmShutdown_q, pinOut_q, pinOe_q;
	logic [7:0]                        portPinIn, analogPinSelect, portRead_q;
	int                                fails = 0, checks = 0, cycles = 0;
	comparator_output_control DUT
	(
		.ref_clk, .arst_n, .cmpCfg, .rawResult, .timerClkLevel, .flagClear,
		.peripheralIrqEnable, .globalIrqEnable, .pinDirection, .portLatch,
		.portPinIn, .analogPinSelect, .analogCtl_q, .cmpResult_q,
		.sharedResultReg_q, .irqFlag_q, .cpuIrq_q, .timerGate_q,
		.pwmShutdown_q, .pinOut_q, .pinOe_q, .portRead_q
	);
	far_side_model farSide
	(
		.ref_clk, .arst_n, .timerRun, .plusSrc, .minusSrc, .rawResult,
		.analogCtl (analogCtl_q), .timerGate (timerGate_q), .timerClkLevel
	);
	// ==========================================================
	// Tasks.
	task automatic check(input logic [7:0] got, exp, input string msg);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	task automatic settle();
		repeat (12) @(posedge ref_clk);
		#1;
	endtask
	task automatic sel(input int i, input logic [1:0] p, n);
		@(posedge ref_clk);
		cmpCfg[i].positiveChannelSelect <= p;
		cmpCfg[i].negativeChannelSelect <= n;
		settle();
	endtask
	task automatic clear();
		@(posedge ref_clk);
		flagClear[0] <= 1'h1;
		@(posedge ref_clk);
		flagClear[0] <= 1'h0;
		settle();
	endtask
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic test_select();
		logic e;
		@(posedge ref_clk);
		cmpCfg[0].cmpEnable <= 1'h1;
		cmpCfg[0].hysteresisEnable <= 1'h1;
		for (int p = 0; p < 4; p++)
			for (int n = 0; n < 4; n++)
			begin
				sel(0, p[1:0], n[1:0]);
				e = ((p == 3) ? 8'h00 : plusSrc[p]) > minusSrc[n];
				check(cmpResult_q[0], e, "result");
				check({analogCtl_q[0].posSel, analogCtl_q[0].negSel},
					{4'h0, p[1:0], n[1:0]}, "select");
			end
		check(analogCtl_q[0].hystOn, 1'h1, "hysteresis");
		check(analogCtl_q[0].fastMode, 1'h0, "low power");
		check(analogCtl_q[0].powerOn, 1'h1, "power on");
		check(analogCtl_q[1].posConnect, 1'h0, "inputs off");
		@(posedge ref_clk);
		cmpCfg[0].outputInvert <= 1'h1;
		settle();
		check(cmpResult_q[0], !e, "invert");
		$display("select test done");
	endtask
	task automatic test_pin();
		sel(0, 2'h2, 2'h0);
		for (int k = 0; k < 8; k++)
		begin
			@(posedge ref_clk);
			cmpCfg[0].pinOutputEnable <= k[0];
			pinDirection[0] <= k[1];
			cmpCfg[0].cmpEnable <= k[2];
			settle();
			check(pinOe_q[0], !k[1] && (!k[0] || k[2]), "pin oe");
			check(pinOut_q[0], k[0] ? !k[2] : 1'h0, "pin data");
			check(pwmShutdown_q[0], !k[2], "shutdown");
		end
		$display("pin test done");
	endtask
	task automatic test_irq();
		@(posedge ref_clk);
		cmpCfg[0].outputInvert <= 1'h0;
		peripheralIrqEnable <= 1'h1;
		sel(0, 2'h0, 2'h0);
		@(posedge ref_clk);
		cmpCfg[0].riseEdgeEnable <= 1'h1;
		cmpCfg[0].cmpIrqEnable <= 1'h1;
		sel(0, 2'h2, 2'h0);
		check(irqFlag_q[0], 1'h1, "rise flag");
		check(cpuIrq_q, 1'h0, "gated irq");
		@(posedge ref_clk);
		globalIrqEnable <= 1'h1;
		settle();
		check(cpuIrq_q, 1'h1, "cpu irq");
		clear();
		check(irqFlag_q[0], 1'h0, "cleared");
		sel(0, 2'h0, 2'h0);
		check(irqFlag_q[0], 1'h0, "fall off");
		@(posedge ref_clk);
		cmpCfg[0].riseEdgeEnable <= 1'h0;
		cmpCfg[0].fallEdgeEnable <= 1'h1;
		sel(0, 2'h2, 2'h0);
		check(irqFlag_q[0], 1'h0, "rise off");
		sel(0, 2'h0, 2'h0);
		check(irqFlag_q[0], 1'h1, "fall flag");
		clear();
		@(posedge ref_clk);
		cmpCfg[0].cmpEnable <= 1'h0;
		cmpCfg[0].riseEdgeEnable <= 1'h1;
		cmpCfg[0].outputInvert <= 1'h1;
		settle();
		check(irqFlag_q[0], 1'h1, "toggle flag");
		$display("irq test done");
	endtask
	task automatic test_sync();
		@(posedge ref_clk);
		timerRun <= 1'h0;
		cmpCfg[1].cmpEnable <= 1'h1;
		cmpCfg[1].timerSyncEnable <= 1'h1;
		portPinIn <= 8'hFF;
		analogPinSelect <= 8'h0F;
		sel(1, 2'h2, 2'h0);
		check(sharedResultReg_q[1], 1'h1, "shared");
		check(timerGate_q[1], 1'h0, "gate held");
		check(portRead_q, 8'hF0, "port read");
		@(posedge ref_clk);
		timerRun <= 1'h1;
		settle();
		check(timerGate_q[1], 1'h1, "gate synced");
		$display("sync test done");
	endtask
	// ==========================================================
	// Clock, watchdog and main sequence.
	initial
	begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			print_verdict();
		end
	end
	initial
	begin
		{arst_n, peripheralIrqEnable, globalIrqEnable} = 3'h0;
		timerRun = 1'h1;
		plusSrc = {8'hF0, 8'hA0, 8'h60, 8'h10};
		minusSrc = {8'h05, 8'hC0, 8'h80, 8'h30};
		cmpCfg = '0;
		{flagClear, pinDirection, portLatch} = '0;
		{portPinIn, analogPinSelect} = 16'h0000;
		@(posedge ref_clk);
		#1;
		check(analogCtl_q[0].fastMode, 1'h1, "speed reset");
		check(irqFlag_q, 8'h00, "flag reset");
		@(posedge ref_clk);
		arst_n <= 1'h1;
		$display("reset test done");
		test_select();
		test_pin();
		test_irq();
		test_sync();
		print_verdict();
	end
endmodule
